// File: ssfm_map.vh
// Purpose: constants for the servo status flag monitor
// Assumes: 32-bit AXI4-Lite register bus, 125 MHz aclk
// Notes:   offsets are byte addresses; flag bit positions shared by status and mask
`ifndef SSFM_MAP_VH
`define SSFM_MAP_VH

// register byte offsets
`define SSFM_OFS_FLAGS      12'h000
`define SSFM_OFS_DIR        12'h004
`define SSFM_OFS_IRQ_STAT   12'h008
`define SSFM_OFS_IRQ_MASK   12'h00C
`define SSFM_OFS_ROUGH_RNG  12'h010
`define SSFM_OFS_INPOS_RNG  12'h014
`define SSFM_OFS_BOUND_A    12'h018
`define SSFM_OFS_BOUND_B    12'h01C
`define SSFM_OFS_CTRL_IN    12'h020

// flag bit positions
`define SSFM_B_ROUGH        0
`define SSFM_B_TRAVEL       1
`define SSFM_B_RANGE        2
`define SSFM_B_READY        3
`define SSFM_B_TOFF         4
`define SSFM_B_CHA          5
`define SSFM_B_CHB          6
`define SSFM_B_TCMD         7
`define SSFM_NFLAGS         8

// direction tags, one = output from amplifier
`define SSFM_DIR_MASK       8'h1F

// controller input bits in the ctrl register
`define SSFM_C_CHA          0
`define SSFM_C_CHB          1
`define SSFM_C_TCMD_N       2

// reset values
`define SSFM_RST_MASK       8'h00
`define SSFM_RST_RANGE      32'h00000000
`define SSFM_RST_CTRL       3'h4

`endif

// File: ssfm_sync.v
// Purpose: two flip-flop synchroniser for a bank of pin levels
// Assumes: inputs are levels from outside the aclk domain
// Notes:   first stage is read only by the second stage
`timescale 1ns/10ps
module ssfm_sync #(
  parameter W = 8
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;

  // two stages to settle metastability
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
    end
  end

  assign q = s2_r;
endmodule

// File: ssfm_eval.v
// Purpose: combinational evaluation of output-type monitor flags
// Assumes: all operands synchronous to aclk; magnitudes unsigned, positions signed
// Notes:   forcing-off terms are applied last so they always win
`timescale 1ns/10ps
module ssfm_eval #(
  parameter DW = 32
) (
  input  wire          base_off,
  input  wire          servo_on,
  input  wire          servo_on_rise,
  input  wire          homed,
  input  wire          ready_state,
  input  wire          toff_active,
  input  wire [DW-1:0] remain_dist,
  input  wire [DW-1:0] droop,
  input  wire [DW-1:0] position,
  input  wire [DW-1:0] rough_rng,
  input  wire [DW-1:0] inpos_rng,
  input  wire [DW-1:0] bound_a,
  input  wire [DW-1:0] bound_b,
  output reg           rough_nxt,
  output reg           travel_nxt,
  output reg           range_nxt,
  output reg           ready_nxt,
  output reg           toff_nxt
);
  reg [DW-1:0] lo;
  reg [DW-1:0] hi;

  // boundaries may be given in either order
  always @* begin
    lo = bound_a;
    hi = bound_b;
    if ($signed(bound_a) > $signed(bound_b)) begin
      lo = bound_b;
      hi = bound_a;
    end
    rough_nxt  = (remain_dist < rough_rng);
    if (servo_on_rise) begin
      rough_nxt = 1'b1;
    end
    if (base_off) begin
      rough_nxt = 1'b0;
    end
    travel_nxt = (droop <= inpos_rng) && (remain_dist == {DW{1'b0}});
    if (servo_on_rise) begin
      travel_nxt = 1'b1;
    end
    if (!servo_on) begin
      travel_nxt = 1'b0;
    end
    range_nxt = ($signed(position) >= $signed(lo)) && ($signed(position) <= $signed(hi));
    if (!homed || base_off) begin
      range_nxt = 1'b0;
    end
    ready_nxt = ready_state;
    toff_nxt  = toff_active;
  end
endmodule

// File: ssfm_top.v
// Purpose: servo status flag monitor with AXI4-Lite register access
// Assumes: drive state inputs come from logic on aclk; wired inputs come from pins
// Notes:   flag rises set sticky interrupt status bits, write one to clear
`timescale 1ns/10ps
`include "ssfm_map.vh"
module ssfm_top #(
  parameter DW = 32
) (
  input  wire          aclk,
  input  wire          aresetn,
  // axi4-lite slave
  input  wire [11:0]   s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output reg           s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output reg           s_axi_wready,
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  input  wire [11:0]   s_axi_araddr,
  input  wire          s_axi_arvalid,
  output reg           s_axi_arready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  // wired pins
  input  wire          pin_channel_a,
  input  wire          pin_channel_b,
  input  wire          pin_command_n,
  // drive state, same clock
  input  wire          base_off,
  input  wire          servo_on,
  input  wire          homed,
  input  wire          ready_state,
  input  wire          toff_active,
  input  wire [DW-1:0] remain_dist,
  input  wire [DW-1:0] droop,
  input  wire [DW-1:0] position,
  // flag outputs
  output reg  [7:0]    monitor_flags,
  output reg  [7:0]    monitor_dir,
  output reg           torque_off_request,
  output reg           irq
);
  localparam NF = `SSFM_NFLAGS;

  wire [2:0]    pin_s;
  reg  [NF-1:0] flags_r;
  reg  [NF-1:0] flags_nxt;
  reg  [NF-1:0] stat_r;
  reg  [NF-1:0] mask_r;
  reg  [31:0]   rough_rng_r;
  reg  [31:0]   inpos_rng_r;
  reg  [31:0]   bound_a_r;
  reg  [31:0]   bound_b_r;
  reg  [2:0]    ctrl_r;
  reg           servo_on_d_r;
  reg  [11:0]   awaddr_r;
  reg           aw_held_r;
  reg  [31:0]   wdata_r;
  reg  [3:0]    wstrb_r;
  reg           w_held_r;
  wire          rough_nxt;
  wire          travel_nxt;
  wire          range_nxt;
  wire          ready_nxt;
  wire          toff_nxt;
  wire          do_write;
  wire          wr_stat;
  reg  [NF-1:0] clr_bits;
  wire [31:0]   mask_wr;

  // merge byte lanes into an old word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  be;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (be[k]) begin
          merge[k*8 +: 8] = nw[k*8 +: 8];
        end
      end
    end
  endfunction

  // address decode shared by read and write paths
  function hit;
    input [11:0] a;
    input [11:0] ofs;
    begin
      hit = (a[11:2] == ofs[11:2]);
    end
  endfunction

  // command pin inverted ahead of the stages so their reset level reads as idle, not a request
  ssfm_sync #(
    .W (3)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({~pin_command_n, pin_channel_b, pin_channel_a}),
    .q       (pin_s)
  );

  ssfm_eval #(
    .DW (DW)
  ) u_eval (
    .base_off      (base_off),
    .servo_on      (servo_on),
    .servo_on_rise (servo_on & ~servo_on_d_r),
    .homed         (homed),
    .ready_state   (ready_state),
    .toff_active   (toff_active),
    .remain_dist   (remain_dist),
    .droop         (droop),
    .position      (position),
    .rough_rng     (rough_rng_r[DW-1:0]),
    .inpos_rng     (inpos_rng_r[DW-1:0]),
    .bound_a       (bound_a_r[DW-1:0]),
    .bound_b       (bound_b_r[DW-1:0]),
    .rough_nxt     (rough_nxt),
    .travel_nxt    (travel_nxt),
    .range_nxt     (range_nxt),
    .ready_nxt     (ready_nxt),
    .toff_nxt      (toff_nxt)
  );

  // input flags: wired pin or controller bit; the command pin arrives already inverted
  always @* begin
    flags_nxt = {NF{1'b0}};
    flags_nxt[`SSFM_B_ROUGH]  = rough_nxt;
    flags_nxt[`SSFM_B_TRAVEL] = travel_nxt;
    flags_nxt[`SSFM_B_RANGE]  = range_nxt;
    flags_nxt[`SSFM_B_READY]  = ready_nxt;
    flags_nxt[`SSFM_B_TOFF]   = toff_nxt;
    flags_nxt[`SSFM_B_CHA]    = pin_s[0] | ctrl_r[`SSFM_C_CHA];
    flags_nxt[`SSFM_B_CHB]    = pin_s[1] | ctrl_r[`SSFM_C_CHB];
    // command flag is on (asserted) when either source sends the off level
    flags_nxt[`SSFM_B_TCMD]   = pin_s[2] | ~ctrl_r[`SSFM_C_TCMD_N];
  end

  // write handshake: address and data taken independently, in either order
  assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_stat  = do_write && hit(awaddr_r, `SSFM_OFS_IRQ_STAT);

  // mask merged at full word width, then cut on purpose to the implemented bits
  assign mask_wr  = merge({24'h000000, mask_r}, wdata_r, wstrb_r);

  always @* begin
    clr_bits = {NF{1'b0}};
    if (wr_stat) begin
      clr_bits = wdata_r[NF-1:0] & {NF{wstrb_r[0]}};
    end
  end

  // flags refreshed every cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      flags_r            <= {NF{1'b0}};
      servo_on_d_r       <= 1'b0;
      monitor_flags      <= 8'h00;
      monitor_dir        <= 8'h00;
      torque_off_request <= 1'b0;
      stat_r             <= {NF{1'b0}};
      irq                <= 1'b0;
    end else begin
      flags_r            <= flags_nxt;
      servo_on_d_r       <= servo_on;
      monitor_flags      <= flags_nxt;
      monitor_dir        <= `SSFM_DIR_MASK;
      torque_off_request <= flags_nxt[`SSFM_B_TCMD];
      // a rise in the same cycle as a clear keeps the bit set
      stat_r             <= (stat_r & ~clr_bits) | (flags_nxt & ~flags_r);
      irq                <= |(((stat_r & ~clr_bits) | (flags_nxt & ~flags_r)) & mask_r);
    end
  end

  // axi write channels
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      awaddr_r      <= 12'h000;
      wdata_r       <= 32'h00000000;
      wstrb_r       <= 4'h0;
      mask_r        <= `SSFM_RST_MASK;
      rough_rng_r   <= `SSFM_RST_RANGE;
      inpos_rng_r   <= `SSFM_RST_RANGE;
      bound_a_r     <= `SSFM_RST_RANGE;
      bound_b_r     <= `SSFM_RST_RANGE;
      ctrl_r        <= `SSFM_RST_CTRL;
    end else begin
      s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awready && s_axi_awvalid) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'b00;
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        // configuration is loaded here; read-only and unmapped words answer okay
        if (hit(awaddr_r, `SSFM_OFS_IRQ_MASK)) begin
          mask_r <= mask_wr[NF-1:0];
        end
        if (hit(awaddr_r, `SSFM_OFS_ROUGH_RNG)) begin
          rough_rng_r <= merge(rough_rng_r, wdata_r, wstrb_r);
        end
        if (hit(awaddr_r, `SSFM_OFS_INPOS_RNG)) begin
          inpos_rng_r <= merge(inpos_rng_r, wdata_r, wstrb_r);
        end
        if (hit(awaddr_r, `SSFM_OFS_BOUND_A)) begin
          bound_a_r <= merge(bound_a_r, wdata_r, wstrb_r);
        end
        if (hit(awaddr_r, `SSFM_OFS_BOUND_B)) begin
          bound_b_r <= merge(bound_b_r, wdata_r, wstrb_r);
        end
        if (hit(awaddr_r, `SSFM_OFS_CTRL_IN) && wstrb_r[0]) begin
          ctrl_r <= wdata_r[2:0];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi read channel, one outstanding read
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        s_axi_rdata  <= 32'h00000000;
        if (hit(s_axi_araddr, `SSFM_OFS_FLAGS)) begin
          s_axi_rdata <= {24'h000000, flags_r};
        end
        if (hit(s_axi_araddr, `SSFM_OFS_DIR)) begin
          s_axi_rdata <= {24'h000000, `SSFM_DIR_MASK};
        end
        if (hit(s_axi_araddr, `SSFM_OFS_IRQ_STAT)) begin
          s_axi_rdata <= {24'h000000, stat_r};
        end
        if (hit(s_axi_araddr, `SSFM_OFS_IRQ_MASK)) begin
          s_axi_rdata <= {24'h000000, mask_r};
        end
        if (hit(s_axi_araddr, `SSFM_OFS_ROUGH_RNG)) begin
          s_axi_rdata <= rough_rng_r;
        end
        if (hit(s_axi_araddr, `SSFM_OFS_INPOS_RNG)) begin
          s_axi_rdata <= inpos_rng_r;
        end
        if (hit(s_axi_araddr, `SSFM_OFS_BOUND_A)) begin
          s_axi_rdata <= bound_a_r;
        end
        if (hit(s_axi_araddr, `SSFM_OFS_BOUND_B)) begin
          s_axi_rdata <= bound_b_r;
        end
        if (hit(s_axi_araddr, `SSFM_OFS_CTRL_IN)) begin
          s_axi_rdata <= {29'h00000000, ctrl_r};
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// File: ssfm_chk_sva.sv
// Purpose: port checker for the servo status flag monitor
// Assumes: one aclk domain; flags lag drive inputs by one cycle and pins by three
// Notes:   setting registers are not visible here, the bench covers those
`timescale 1ns/10ps
module ssfm_chk (
  input wire       aclk,
  input wire       aresetn,
  input wire       base_off,
  input wire       servo_on,
  input wire       homed,
  input wire       ready_state,
  input wire       toff_active,
  input wire       pin_channel_a,
  input wire       pin_channel_b,
  input wire       pin_command_n,
  input wire [7:0] monitor_flags,
  input wire [7:0] monitor_dir,
  input wire       torque_off_request,
  input wire       irq
);
  reg  [1:0] up_r;
  reg        svo_r;
  reg        rise_r;
  wire       ok;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // flags are trusted only once the pipeline has refilled after any reset
  always @(posedge aclk) begin
    if (!aresetn)
      up_r <= 2'h0;
    else if (up_r != 2'h3)
      up_r <= up_r + 2'h1;
    svo_r <= servo_on;
    rise_r <= servo_on & ~svo_r & ~base_off & ok & aresetn;
  end
  assign ok = (up_r == 2'h3);
  dir_tag_a: assert property (ok |-> monitor_dir == 8'h1F)
    else $error("direction tags wrong");
  servo_rise_a: assert property (rise_r |-> monitor_flags[0] && monitor_flags[1])
    else $error("servo on did not raise rough and travel flags");
  rough_shut_a: assert property (ok && $past(base_off) |-> !monitor_flags[0])
    else $error("rough match on during shut off");
  travel_off_a: assert property (ok && $past(servo_on) == 1'b0 |-> !monitor_flags[1])
    else $error("travel complete on while servo off");
  range_off_a: assert property (ok && (!$past(homed) || $past(base_off)) |->
    !monitor_flags[2])
    else $error("position range on while forced off");
  ready_flag_a: assert property (ok |-> monitor_flags[3] == $past(ready_state))
    else $error("ready flag does not follow state");
  toff_flag_a: assert property (ok |-> monitor_flags[4] == $past(toff_active))
    else $error("torque off state flag wrong");
  chan_a_pin_a: assert property ((ok && pin_channel_a) [*3] |=> monitor_flags[5])
    else $error("channel a pin not reported");
  chan_b_pin_a: assert property ((ok && pin_channel_b) [*3] |=> monitor_flags[6])
    else $error("channel b pin not reported");
  cmd_pin_a: assert property ((ok && !pin_command_n) [*3] |=>
    torque_off_request && monitor_flags[7])
    else $error("low command pin did not request torque off");
  cover property (rise_r);
  cover property (irq);
  cover property (ok && monitor_flags[2]);
  cover property (ok && monitor_flags[1] && !rise_r);
endmodule
bind ssfm_top ssfm_chk i_ssfm_chk (.aclk(aclk), .aresetn(aresetn), .base_off(base_off),
  .servo_on(servo_on), .homed(homed), .ready_state(ready_state), .toff_active(toff_active),
  .pin_channel_a(pin_channel_a), .pin_channel_b(pin_channel_b),
  .pin_command_n(pin_command_n), .monitor_flags(monitor_flags), .monitor_dir(monitor_dir),
  .torque_off_request(torque_off_request), .irq(irq));

// File: ssfm_ctl.sv
// Purpose: motion controller model, an AXI4-Lite master reading and commanding
// Assumes: tasks are entered right after a rising aclk edge
// Notes:   released address and data show their inverse so stale values are not trusted
`timescale 1ns/10ps
module ssfm_ctl (
  input  wire        aclk,
  output reg  [11:0] s_axi_awaddr = 12'h000,
  output reg         s_axi_awvalid = 1'b0,
  input  wire        s_axi_awready,
  output reg  [31:0] s_axi_wdata = 32'h00000000,
  output reg  [3:0]  s_axi_wstrb = 4'hF,
  output reg         s_axi_wvalid = 1'b0,
  input  wire        s_axi_wready,
  input  wire        s_axi_bvalid,
  output reg         s_axi_bready = 1'b0,
  output reg  [11:0] s_axi_araddr = 12'h000,
  output reg         s_axi_arvalid = 1'b0,
  input  wire        s_axi_arready,
  input  wire [31:0] s_axi_rdata,
  input  wire        s_axi_rvalid,
  output reg         s_axi_rready = 1'b0
);
  // write: address and data offered together, each dropped once taken
  task wr(input [11:0] a, input [31:0] d);
    reg aw_t;
    reg w_t;
    begin
      aw_t = 1'b0;
      w_t = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw_t && w_t)) begin
        @(posedge aclk);
        if (s_axi_awvalid && s_axi_awready) begin
          aw_t = 1'b1;
          s_axi_awvalid <= 1'b0;
          s_axi_awaddr <= ~a;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_t = 1'b1;
          s_axi_wvalid <= 1'b0;
          s_axi_wdata <= ~d;
        end
      end
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      while (!s_axi_bvalid) @(posedge aclk);
      s_axi_bready <= 1'b0;
    end
  endtask
  // read: data is taken at the edge where rvalid is seen
  task rd(input [11:0] a, output [31:0] d);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      @(posedge aclk);
      while (!s_axi_arready) @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      s_axi_araddr <= ~a;
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      while (!s_axi_rvalid) @(posedge aclk);
      d = s_axi_rdata;
      s_axi_rready <= 1'b0;
    end
  endtask
endmodule

// File: tb_top.sv
// Purpose: self-checking bench for the servo status flag monitor
// Assumes: flags settle within five cycles of an input change
// Notes:   expected flags come from a behavioural model of the drive conditions
`timescale 1ns/10ps
`include "ssfm_map.vh"
module tb_top;
  reg         aclk = 1'b0;
  reg         aresetn = 1'b0;
  reg         pin_channel_a = 1'b0, pin_channel_b = 1'b0, pin_command_n = 1'b1;
  reg         base_off = 1'b0, servo_on = 1'b0, homed = 1'b0;
  reg         ready_state = 1'b0, toff_active = 1'b0;
  reg  [31:0] remain_dist = 32'h0, droop = 32'h0, position = 32'h0;
  reg  [31:0] seed = 32'h294D, rd_v, ctrl_v, rr, ip, ba, bb;
  wire [11:0] s_axi_awaddr, s_axi_araddr;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [3:0]  s_axi_wstrb;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  wire        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  wire [7:0]  monitor_flags, monitor_dir;
  wire        torque_off_request, irq;
  integer     n_errors = 0, checks_done = 0, cyc = 0, k;
  ssfm_top i_ssfm_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .pin_channel_a(pin_channel_a), .pin_channel_b(pin_channel_b),
    .pin_command_n(pin_command_n), .base_off(base_off), .servo_on(servo_on), .homed(homed),
    .ready_state(ready_state), .toff_active(toff_active), .remain_dist(remain_dist),
    .droop(droop), .position(position), .monitor_flags(monitor_flags),
    .monitor_dir(monitor_dir), .torque_off_request(torque_off_request), .irq(irq));
  ssfm_ctl i_ssfm_ctl (.aclk(aclk), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  // 125 MHz clock
  initial forever #4 aclk = ~aclk;
  // hang guard, well above the under two thousand cycles the run needs
  always @(posedge aclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      tally_and_finish;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task rdchk(input [11:0] a, input [31:0] exp);
    begin
      i_ssfm_ctl.rd(a, rd_v);
      chk(rd_v, exp);
      chk(s_axi_rresp, 32'h0);
    end
  endtask
  // every write response taken by the controller must be okay
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready)
      chk(s_axi_bresp, 32'h0);
  end
  // expected flags; forcing-off terms are folded into the rough, travel and range products
  function automatic [7:0] model();
    reg signed [31:0] lo, hi;
    begin
      lo = ($signed(ba) < $signed(bb)) ? ba : bb;
      hi = ($signed(ba) < $signed(bb)) ? bb : ba;
      model[0] = !base_off && remain_dist < rr;
      model[1] = servo_on && droop <= ip && remain_dist == 32'h0;
      model[2] = homed && !base_off && $signed(position) >= lo && $signed(position) <= hi;
      model[3] = ready_state;
      model[4] = toff_active;
      model[5] = pin_channel_a | ctrl_v[0];
      model[6] = pin_channel_b | ctrl_v[1];
      model[7] = !pin_command_n | !ctrl_v[2];
    end
  endfunction
  task tally_and_finish;
    begin
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // reset values, settings, random drive conditions, then the interrupt path
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdchk(`SSFM_OFS_CTRL_IN, `SSFM_RST_CTRL);
    rdchk(`SSFM_OFS_IRQ_MASK, 32'h0);
    rdchk(`SSFM_OFS_BOUND_B, `SSFM_RST_RANGE);
    rdchk(`SSFM_OFS_DIR, 32'h1F);
    rdchk(12'h040, 32'h0);
    chk(monitor_dir, 32'h1F);
    rr = ($random(seed) & 32'h7) + 32'h1;
    ip = $random(seed) & 32'h3;
    ba = $random(seed) >>> 29;
    bb = $random(seed) >>> 29;
    i_ssfm_ctl.wr(`SSFM_OFS_ROUGH_RNG, rr);
    i_ssfm_ctl.wr(`SSFM_OFS_INPOS_RNG, ip);
    i_ssfm_ctl.wr(`SSFM_OFS_BOUND_A, ba);
    i_ssfm_ctl.wr(`SSFM_OFS_BOUND_B, bb);
    rdchk(`SSFM_OFS_BOUND_A, ba);
    ctrl_v = `SSFM_RST_CTRL;
    for (k = 0; k < 240; k = k + 1) begin
      {base_off, servo_on, homed, ready_state, toff_active} <= $random(seed);
      {pin_channel_a, pin_channel_b, pin_command_n} <= $random(seed);
      remain_dist <= $random(seed) & 32'h7;
      droop <= $random(seed) & 32'h7;
      position <= $random(seed) >>> 28;
      if (k % 8 == 0) begin
        ctrl_v = $random(seed) & 32'h7;
        i_ssfm_ctl.wr(`SSFM_OFS_CTRL_IN, ctrl_v);
      end
      repeat (5) @(posedge aclk);
      chk(monitor_flags, model());
      chk(torque_off_request, model() >> 7);
      if (k % 16 == 0)
        rdchk(`SSFM_OFS_FLAGS, model());
    end
    ready_state <= 1'b0;
    repeat (3) @(posedge aclk);
    i_ssfm_ctl.wr(`SSFM_OFS_IRQ_STAT, 32'hFF);
    rdchk(`SSFM_OFS_IRQ_STAT, 32'h0);
    ready_state <= 1'b1;
    repeat (3) @(posedge aclk);
    rdchk(`SSFM_OFS_IRQ_STAT, 32'h8);
    chk(irq, 32'h0);
    i_ssfm_ctl.wr(`SSFM_OFS_IRQ_MASK, 32'h8);
    repeat (2) @(posedge aclk);
    chk(irq, 32'h1);
    i_ssfm_ctl.wr(`SSFM_OFS_IRQ_STAT, 32'h8);
    repeat (2) @(posedge aclk);
    chk(irq, 32'h0);
    rdchk(`SSFM_OFS_IRQ_MASK, 32'h8);
    tally_and_finish;
  end
endmodule
